// ### dv/rbnode_peer.sv
// partner: peer ring node answering one message per request
module rbnode_peer (
	// link clock
	input wire logic ringClk,
	// ring pins of the port under test
	input wire logic dutData,
	input wire logic dutOe,
	// message exchange
	input wire logic [31:0] txMsg,
	output logic peerData,
	output logic [31:0] rxMsg
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt = 6'h00;
	// idle line is pulled high, message goes out msb first
	assign peerData = (cnt != 6'h00) ? txMsg[cnt - 6'h01] : 1'b1;
	always @(posedge ringClk) begin
		if (cnt != 6'h00) begin
			rxMsg <= {rxMsg[30:0], dutData};
			cnt <= cnt - 6'h01;
		end else if (dutOe && !dutData) begin
			cnt <= 6'h20;
		end
	end
endmodule : rbnode_peer

// ### dv/rbnode_port_props.sv
// checker: register port and interrupt relations of the ring bus node port
module rbnode_port_props (
	// system clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	input wire logic [7:0] regRdData,
	// clock gating and interrupt
	input wire logic serialClockEnable,
	input wire logic ringIrq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence wrA(logic [7:0] a);
		regWrStrobe && regAddr == a;
	endsequence
	sequence rdA(logic [7:0] a);
		regRdStrobe && regAddr == a;
	endsequence
	//////////////////////////////////////////////////////////////////////
	AST_RD_IDLE: assert property (!regRdStrobe |=> regRdData == 8'h00)
		else $error("read data not zero outside read answer");
	AST_CSR_RESET: assert property ($fell(srst) ##[0:2]
		rdA(rbnode_pkg::ADDR_CSR) |=> regRdData == 8'h00)
		else $error("control status not zero after reset");
	AST_IRQ_RESET: assert property (disable iff (1'b0)
		srst ##1 srst |=> !ringIrq) else $error("irq during reset");
	AST_UNMAPPED: assert property (regRdStrobe &&
		regAddr > rbnode_pkg::ADDR_BUSCTL |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	AST_CLKEN_SET: assert property (wrA(rbnode_pkg::ADDR_CSR)
		##0 regWrData[6] |-> ##[1:2] serialClockEnable)
		else $error("serial clock not enabled");
	AST_CLKEN_HOLD: assert property (serialClockEnable
		|=> serialClockEnable) else $error("clock enable dropped");
	AST_WRPEND_CLR: assert property (wrA(rbnode_pkg::ADDR_MSG0)
		##1 !regWrStrobe ##1 rdA(rbnode_pkg::ADDR_CSR) |=> !regRdData[0])
		else $error("write pending not cleared");
	AST_RDPEND_CLR: assert property (rdA(rbnode_pkg::ADDR_MSG3)
		##2 rdA(rbnode_pkg::ADDR_CSR) |=> !regRdData[4])
		else $error("read pending not cleared");
	AST_INTR_W1C: assert property (wrA(rbnode_pkg::ADDR_CSR)
		##0 regWrData[7] ##2 rdA(rbnode_pkg::ADDR_CSR) |=> !regRdData[7])
		else $error("interrupted flag not cleared");
	AST_IRQ_CAUSE: assert property (rdA(rbnode_pkg::ADDR_CSR)
		##0 ringIrq |=> (regRdData & 8'h1A) != 8'h00)
		else $error("irq without cause");
endmodule : rbnode_port_props
bind rbnode_port rbnode_port_props rbnode_port_props_inst (.clk(clk),
	.srst(srst), .regAddr(regAddr), .regWrData(regWrData),
	.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
	.regRdData(regRdData), .serialClockEnable(serialClockEnable),
	.ringIrq(ringIrq));

// ### dv/testbench.sv
// testbench: register-level tests of the ring bus node port with a peer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ringClk = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrStrobe = 1'b0;
	logic regRdStrobe = 1'b0;
	logic [7:0] regRdData;
	logic dIn, dOut, dOe, serialClockEnable, ringIrq;
	logic [31:0] peerRx;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	localparam logic [31:0] TX = 32'hA1B2C3D4;
	localparam logic [31:0] PEER = 32'hB0123456;
	initial forever #12.5 clk = ~clk;
	initial begin
		#7;
		forever #15 ringClk = ~ringClk;
	end
	rbnode_port rbnode_port_inst (.clk(clk), .srst(srst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStrobe(regWrStrobe),
		.regRdStrobe(regRdStrobe), .regRdData(regRdData), .ringClk(ringClk),
		.ringSerialDataIn(dIn), .ringSerialDataOut(dOut),
		.ringSerialDataOe(dOe), .serialClockEnable(serialClockEnable),
		.ringIrq(ringIrq));
	rbnode_peer rbnode_peer_inst (.ringClk(ringClk), .dutData(dOut),
		.dutOe(dOe), .txMsg(PEER), .peerData(dIn), .rxMsg(peerRx));
	//////////////////////////////////////////////////////////////////////
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			n_fail++;
		end
	endtask : cmp
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge clk);
		regWrStrobe <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge clk);
		regRdStrobe <= 1'b0;
		@(negedge clk);
		cmp("regRdData", {24'h0, e}, {24'h0, regRdData});
	endtask : rd
	task give_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(rbnode_pkg::ADDR_CSR, 8'h00);
		rd(8'h30, 8'h00);
		wr(rbnode_pkg::ADDR_NODEADDR, 8'h05);
		wr(rbnode_pkg::ADDR_BUSCTL, 8'h04);
		for (int i = 3; i >= 0; i--) begin
			wr(rbnode_pkg::ADDR_MSG0 + 8'(i), TX[8*i +: 8]);
		end
		wr(rbnode_pkg::ADDR_CSR, 8'hFF);
		rd(rbnode_pkg::ADDR_CSR, 8'h45);
		cmp("serialClockEnable", 32'h1, serialClockEnable);
		for (int i = 0; i < 2000 && ringIrq !== 1'b1; i++) @(negedge clk);
		cmp("ringIrq", 32'h1, ringIrq);
		rd(rbnode_pkg::ADDR_CSR, 8'hD6);
		cmp("peerRx", TX, peerRx);
		for (int i = 0; i < 4; i++) begin
			rd(rbnode_pkg::ADDR_MSG0 + 8'(i), PEER[8*i +: 8]);
		end
		rd(rbnode_pkg::ADDR_CSR, 8'hC6);
		cmp("ringIrq", 32'h1, ringIrq);
		wr(rbnode_pkg::ADDR_CSR, 8'h00);
		rd(rbnode_pkg::ADDR_CSR, 8'hC6);
		wr(rbnode_pkg::ADDR_CSR, 8'h80);
		rd(rbnode_pkg::ADDR_CSR, 8'h46);
		wr(rbnode_pkg::ADDR_BUSCTL, 8'h00);
		repeat (2) @(negedge clk);
		cmp("ringIrq", 32'h0, ringIrq);
		wr(rbnode_pkg::ADDR_CSR, 8'h01);
		wr(rbnode_pkg::ADDR_MSG0, 8'h00);
		rd(rbnode_pkg::ADDR_CSR, 8'h46);
		give_verdict();
	end
endmodule : testbench

// ### hw/rbnode_link.sv
// link-side shifter: runs on the ring clock, shifts one message bit per rising edge
module rbnode_link (
	// link clock and reset
	input wire logic linkClk,
	input wire logic linkRst,
	// ring pins
	input wire logic ringSerialDataIn,
	output logic ringSerialDataOut,
	output logic ringSerialDataOe,
	// toggle handshakes with core
	input wire logic txReqToggle,
	input wire logic [31:0] txWord,
	output logic doneToggle,
	output logic [31:0] rxWord
);
	typedef struct packed {
		rbnode_pkg::rbnode_state_t state;
		logic [5:0] bitCount;
		logic [31:0] shift;
		logic [1:0] reqSync;
		logic reqSeen;
		logic done;
		logic [31:0] rx;
		logic drive;
		logic dataOut;
	} rbnode_link_t;
	rbnode_link_t r;
	rbnode_link_t next_r;
	always_comb begin
		next_r = r;
		next_r.reqSync = {r.reqSync[0], txReqToggle};
		case (r.state)
			rbnode_pkg::RBN_IDLE: begin
				next_r.drive = 1'b0;
				if (r.reqSync[1] != r.reqSeen) begin
					next_r.reqSeen = r.reqSync[1];
					next_r.shift = txWord;
					next_r.drive = 1'b1;
					next_r.dataOut = 1'b0;
					next_r.state = rbnode_pkg::RBN_REQ;
				end else if (!ringSerialDataIn) begin
					next_r.bitCount = 6'h00;
					next_r.state = rbnode_pkg::RBN_SHIFT;
				end
			end
			rbnode_pkg::RBN_REQ: begin
				next_r.bitCount = 6'h00;
				next_r.dataOut = r.shift[rbnode_pkg::MSG_BITS-1];
				next_r.state = rbnode_pkg::RBN_SHIFT;
			end
			rbnode_pkg::RBN_SHIFT: begin
				next_r.shift = {r.shift[30:0], ringSerialDataIn};
				next_r.dataOut = r.shift[30];
				next_r.bitCount = r.bitCount + 6'h01;
				if (r.bitCount == rbnode_pkg::LAST_BIT) begin
					next_r.state = rbnode_pkg::RBN_DONE;
				end
			end
			default: begin
				next_r.drive = 1'b0;
				next_r.rx = r.shift;
				next_r.done = ~r.done;
				next_r.state = rbnode_pkg::RBN_IDLE;
			end
		endcase
	end
	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign ringSerialDataOut = r.dataOut;
	assign ringSerialDataOe = r.drive;
	assign doneToggle = r.done;
	assign rxWord = r.rx;
endmodule : rbnode_link

// ### hw/rbnode_port.sv
// ring bus node message port: message bytes, control/status, ring shifter
// Operation
// - four byte registers form the 32-bit transmit and receive message words.
// - the top three bits of the top message byte are the bus-address field.
// - reading the top message byte clears read-pending.
// - writing the bottom message byte clears write-pending.
// - the four byte addresses read received data and write transmit data.
// - software can only set bits 0, 2 and 6 of the control/status reg.
// - reset clears the whole control/status register.
// - writing one to the interrupted bit clears it; zero leaves it.
// - the interrupt request is bus enable and any of master, nack, rdpend.
// - the clock enable bit drives the serialClockEnable output; ringClk is not gated.
// - read-pending sets when an incoming address field matches ours.
// - an idle node with write pending pulls data low to request the clock.
module rbnode_port (
	// system clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [7:0] regRdData,
	// ring link
	input wire logic ringClk,
	input wire logic ringSerialDataIn,
	output logic ringSerialDataOut,
	output logic ringSerialDataOe,
	// clock gating and interrupt
	output logic serialClockEnable,
	output logic ringIrq
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [31:0] txMsg;
		logic [31:0] rxMsg;
		logic [7:0] csr;
		logic [2:0] nodeAddr;
		logic [7:0] busCtl;
		logic txToggle;
		logic [1:0] doneSync;
		logic doneSeen;
		logic [1:0] rstSync;
		logic [7:0] rdData;
	} rbnode_core_t;
	rbnode_core_t r;
	rbnode_core_t next_r;
	logic linkDone;
	logic [31:0] linkRx;
	logic linkRst;

	function automatic logic [1:0] byteIndex(input logic [7:0] a);
		byteIndex = 2'(a - rbnode_pkg::ADDR_MSG0);
	endfunction : byteIndex

	function automatic logic isMsg(input logic [7:0] a);
		isMsg = (a >= rbnode_pkg::ADDR_MSG0) && (a <= rbnode_pkg::ADDR_MSG3);
	endfunction : isMsg

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		next_r.doneSync = {r.doneSync[0], linkDone};
		next_r.rstSync = {r.rstSync[0], srst};
		next_r.rdData = 8'h00;
		// register read
		if (regRdStrobe) begin
			if (isMsg(regAddr)) begin
				next_r.rdData = r.rxMsg[8*byteIndex(regAddr) +: 8];
				if (regAddr == rbnode_pkg::ADDR_MSG3) begin
					next_r.csr[rbnode_pkg::BIT_RDPEND] = 1'b0;
				end
			end else if (regAddr == rbnode_pkg::ADDR_CSR) begin
				next_r.rdData = r.csr;
			end else if (regAddr == rbnode_pkg::ADDR_NODEADDR) begin
				next_r.rdData = {5'h00, r.nodeAddr};
			end else if (regAddr == rbnode_pkg::ADDR_BUSCTL) begin
				next_r.rdData = r.busCtl;
			end
		end
		// register write
		if (regWrStrobe) begin
			if (isMsg(regAddr)) begin
				next_r.txMsg[8*byteIndex(regAddr) +: 8] = regWrData;
				if (regAddr == rbnode_pkg::ADDR_MSG0) begin
					next_r.csr[rbnode_pkg::BIT_WRPEND] = 1'b0;
				end
			end else if (regAddr == rbnode_pkg::ADDR_CSR) begin
				next_r.csr = r.csr | (regWrData & rbnode_pkg::CSR_WRITABLE
					& 8'h7F);
				if (regWrData[rbnode_pkg::BIT_INTR]) begin
					next_r.csr[rbnode_pkg::BIT_INTR] = 1'b0;
				end
				if (regWrData[rbnode_pkg::BIT_WRPEND]
						&& !r.csr[rbnode_pkg::BIT_WRPEND]) begin
					next_r.txToggle = ~r.txToggle;
				end
			end else if (regAddr == rbnode_pkg::ADDR_NODEADDR) begin
				next_r.nodeAddr = regWrData[2:0];
			end else if (regAddr == rbnode_pkg::ADDR_BUSCTL) begin
				next_r.busCtl = regWrData;
			end
		end
		// message finished on the ring; hardware set wins over clears
		if (r.doneSync[1] != r.doneSeen) begin
			next_r.doneSeen = r.doneSync[1];
			next_r.rxMsg = linkRx;
			if (linkRx[31:rbnode_pkg::ADDR_FIELD_LSB]
					== r.nodeAddr) begin
				next_r.csr[rbnode_pkg::BIT_RDPEND] = 1'b1;
				next_r.csr[rbnode_pkg::BIT_INTR] = 1'b1;
			end
			if (r.csr[rbnode_pkg::BIT_WRPEND]) begin
				next_r.csr[rbnode_pkg::BIT_MASTER] = 1'b1;
				next_r.csr[rbnode_pkg::BIT_PREVMST] = 1'b1;
				next_r.csr[rbnode_pkg::BIT_WRPEND] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r.txMsg <= '0;
			r.rxMsg <= '0;
			r.csr <= rbnode_pkg::CSR_RESET;
			r.nodeAddr <= '0;
			r.busCtl <= '0;
			r.txToggle <= 1'b0;
			r.doneSync <= '0;
			r.doneSeen <= 1'b0;
			r.rstSync <= 2'b11;
			r.rdData <= '0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link reset follows system reset through the ring clock domain
	logic [1:0] linkRstSync;
	always_ff @(posedge ringClk) begin
		linkRstSync <= {linkRstSync[0], r.rstSync[1]};
	end
	assign linkRst = linkRstSync[1];

	rbnode_link u_link (
		.linkClk(ringClk),
		.linkRst(linkRst),
		.ringSerialDataIn(ringSerialDataIn),
		.ringSerialDataOut(ringSerialDataOut),
		.ringSerialDataOe(ringSerialDataOe),
		.txReqToggle(r.txToggle),
		.txWord(r.txMsg),
		.doneToggle(linkDone),
		.rxWord(linkRx)
	);

	assign regRdData = r.rdData;
	assign serialClockEnable = r.csr[rbnode_pkg::BIT_CLKEN];
	assign ringIrq = r.busCtl[rbnode_pkg::BIT_BUSEN]
		& (r.csr[rbnode_pkg::BIT_MASTER] | r.csr[rbnode_pkg::BIT_NACK]
		| r.csr[rbnode_pkg::BIT_RDPEND]);
endmodule : rbnode_port

// ### inc/rbnode_pkg.sv
// package: register map, field positions and states of the ring bus node port
package rbnode_pkg;
	localparam logic [7:0] ADDR_MSG0 = 8'h15;
	localparam logic [7:0] ADDR_MSG1 = 8'h16;
	localparam logic [7:0] ADDR_MSG2 = 8'h17;
	localparam logic [7:0] ADDR_MSG3 = 8'h18;
	localparam logic [7:0] ADDR_CSR = 8'h22;
	localparam logic [7:0] ADDR_NODEADDR = 8'h23;
	localparam logic [7:0] ADDR_BUSCTL = 8'h24;
	localparam int BIT_WRPEND = 0;
	localparam int BIT_MASTER = 1;
	localparam int BIT_PREVMST = 2;
	localparam int BIT_NACK = 3;
	localparam int BIT_RDPEND = 4;
	localparam int BIT_DEAF = 5;
	localparam int BIT_CLKEN = 6;
	localparam int BIT_INTR = 7;
	localparam logic [7:0] CSR_WRITABLE = 8'hC5;
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam int BIT_BUSEN = 2;
	localparam int ADDR_FIELD_LSB = 29;
	localparam int MSG_BITS = 32;
	localparam logic [5:0] LAST_BIT = 6'h1F;
	typedef enum logic [1:0] {
		RBN_IDLE = 2'b00,
		RBN_REQ = 2'b01,
		RBN_SHIFT = 2'b10,
		RBN_DONE = 2'b11
	} rbnode_state_t;
endpackage : rbnode_pkg
